// ### logic/flic_defines.svh
// Register offsets, field positions and reset values of the interrupt controller
`ifndef FLIC_DEFINES_SVH
`define FLIC_DEFINES_SVH

`define FLIC_ADDR_IEN_PRI 8'ha8
`define FLIC_ADDR_IEN_SEC 8'he8
`define FLIC_ADDR_PRIO_LO0 8'hb8
`define FLIC_ADDR_PRIO_HI0 8'hb7
`define FLIC_ADDR_PRIO_LO1 8'hf8
`define FLIC_ADDR_PRIO_HI1 8'hf7
`define FLIC_ADDR_FLAG_A 8'hc0
`define FLIC_ADDR_FLAG_B 8'hc1
`define FLIC_ADDR_FLAG_C 8'hc2
`define FLIC_ADDR_INSVC 8'hc3

`define FLIC_REG_RST 8'h00
`define FLIC_RD_ZERO 8'h00
`define FLIC_GLOBAL_BIT 7
`define FLIC_NUM_SRC 15
`define FLIC_NUM_LVL 4

// Flag group A
`define FLIC_FA_EXT0 0
`define FLIC_FA_T0 1
`define FLIC_FA_EXT1 2
`define FLIC_FA_T1 3
`define FLIC_FA_RX 4
`define FLIC_FA_TX 5
`define FLIC_FA_I2C 6
`define FLIC_FA_ADC 7
`define FLIC_FA_SET_OK 8'h7f
// Flag group B and C
`define FLIC_FB_CAP_LSB 0
`define FLIC_FB_CMP_LSB 4
`define FLIC_FC_BYTE_OV 0
`define FLIC_FC_FULL_OV 1
`define FLIC_FB_SET_OK 7'h7f
`define FLIC_FC_SET_OK 2'h3

`define FLIC_BYTE_MAX 8'hff
`define FLIC_BYTE_ZERO 8'h00
`define FLIC_WORD_MAX 16'hffff
`define FLIC_WORD_ZERO 16'h0000

`endif

// ### logic/flic_flag_bank.sv
// Request flags with hardware set and software write, set winning
`default_nettype none
`include "flic_defines.svh"
module flic_flag_bank #(
   parameter int W = 8,
   parameter logic [W-1:0] SET_OK = '1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Hardware events and software access
   input wire logic [W-1:0] hw_set,
   input wire logic sw_wr,
   input wire logic [W-1:0] sw_data,
   // Flags
   output logic [W-1:0] flags
);
   logic [W-1:0] flag_next;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // A bit that software may not set only takes a written zero
         wire sw_bit = SET_OK[i] ? sw_data[i] : (sw_data[i] & flags[i]);
         assign flag_next[i] = hw_set[i] | (sw_wr ? sw_bit : flags[i]);
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         flags <= '0;
      end else begin
         flags <= flag_next;
      end
   end
endmodule : flic_flag_bank
`default_nettype wire

// ### logic/flic_pkg.sv
// Types shared by the interrupt controller modules
`default_nettype none
package flic_pkg;
   typedef logic [1:0] flic_level_t;
   typedef logic [3:0] flic_src_t;
   typedef logic [7:0] flic_byte_t;

   typedef struct packed {
      logic valid;
      flic_level_t level;
      flic_src_t source;
   } flic_grant_s;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] cmp0;
      logic [15:0] cmp1;
      logic [15:0] cmp2;
      logic [3:0] capture;
   } flic_t2_s;

   typedef struct packed {
      logic ack;
      logic ret;
   } flic_core_s;
endpackage : flic_pkg
`default_nettype wire

// ### logic/flic_prio_pick.sv
// Picks the highest-level pending source, lowest index on a tie
`default_nettype none
`include "flic_defines.svh"
module flic_prio_pick (
   // Pending requests and their priority bits
   input wire logic [`FLIC_NUM_SRC-1:0] req,
   input wire logic [`FLIC_NUM_SRC-1:0] prio_hi,
   input wire logic [`FLIC_NUM_SRC-1:0] prio_lo,
   // Winner
   output flic_pkg::flic_grant_s grant
);
   import flic_pkg::*;

   always_comb begin
      flic_level_t lvl;
      lvl = '0;
      grant = '0;
      for (int i = 0; i < `FLIC_NUM_SRC; i++) begin
         lvl = {prio_hi[i], prio_lo[i]};
         // Strict compare keeps the earliest index among equals
         if (req[i] && (!grant.valid || lvl > grant.level)) begin
            grant.valid = 1'b1;
            grant.level = lvl;
            grant.source = 4'(i);
         end
      end
   end
endmodule : flic_prio_pick
`default_nettype wire

// ### logic/flic_top.sv
// Fifteen-source, four-level nested interrupt controller
//
// Strobed register access was left to the implementer.
`default_nettype none
`include "flic_defines.svh"
// How it works
// - Fifteen sources, each given one of four priority levels.
// - Two external pins, timer 0, timer 1, UART as OR of rx/tx done.
// - The capture/compare timer gives four capture, three compare, one overflow request.
// - Each capture flag is set by an edge on its capture input.
// - Each compare flag is set when a fresh timer count equals its compare register.
// - Low byte wrap sets byte overflow; full wrap sets full overflow.
// - Timer flags are never cleared by hardware; software clears them.
// - Converter-done flag makes the ADC request; only software clears it.
// - Software may clear the converter-done flag; writing one does nothing.
// - The I2C flag is set when a valid status code is loaded.
// - All other flags are software writable, same effect as hardware.
// - Each source has an enable bit; cleared bit blocks its request.
// - Top bit of the primary enable register is the global enable.
// - Primary bits 6..0 enable ADC, I2C, UART, timer1, ext1, timer0, ext0.
// - Level is high-priority bit over low-priority bit; 11 is highest.
// - A request waits while an equal or higher level is in service.
// - A higher level preempts; the preempted service resumes afterwards.
// - Secondary bits: 7 overflow, 6..4 compare 2..0, 3..0 capture 3..0.
// - An enable bit at zero disables its source, at one enables it.
module flic_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Standard sources
   input wire logic ext_irq_pin0,
   input wire logic ext_irq_pin1,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic uart_rx_done,
   input wire logic uart_tx_done,
   input wire logic i2c_status_load,
   input wire logic i2c_status_valid,
   input wire logic converter_result_ready,
   // Capture/compare timer
   input wire flic_pkg::flic_t2_s t2_in,
   // Processor core
   input wire flic_pkg::flic_core_s core_in,
   output flic_pkg::flic_grant_s core_req,
   output logic [3:0] in_service
);
   import flic_pkg::*;

   // Register state
   flic_byte_t ien_pri_reg;
   flic_byte_t ien_sec_reg;
   flic_byte_t prio_lo0_reg;
   flic_byte_t prio_hi0_reg;
   flic_byte_t prio_lo1_reg;
   flic_byte_t prio_hi1_reg;
   flic_byte_t rdata_reg;
   flic_byte_t rdata_next;
   logic [3:0] in_svc_reg;
   logic [3:0] in_svc_next;
   flic_grant_s grant_reg;
   flic_grant_s grant_next;

   // Edge and wrap history
   logic ext0_prev_reg;
   logic ext1_prev_reg;
   logic [3:0] cap_prev_reg;
   logic [15:0] count_prev_reg;

   // Flags
   logic [7:0] flag_a;
   logic [6:0] flag_b;
   logic [1:0] flag_c;

   // Highest level now in service
   function automatic flic_level_t top_level(input logic [3:0] svc);
      top_level = '0;
      for (int l = 0; l < `FLIC_NUM_LVL; l++) begin
         if (svc[l]) begin
            top_level = 2'(l);
         end
      end
   endfunction : top_level

   function automatic logic [3:0] level_bit(input flic_level_t lvl);
      level_bit = 4'h1 << lvl;
   endfunction : level_bit

   // Address decode
   wire sel_ien_pri = reg_addr == `FLIC_ADDR_IEN_PRI;
   wire sel_ien_sec = reg_addr == `FLIC_ADDR_IEN_SEC;
   wire sel_lo0 = reg_addr == `FLIC_ADDR_PRIO_LO0;
   wire sel_hi0 = reg_addr == `FLIC_ADDR_PRIO_HI0;
   wire sel_lo1 = reg_addr == `FLIC_ADDR_PRIO_LO1;
   wire sel_hi1 = reg_addr == `FLIC_ADDR_PRIO_HI1;
   wire sel_fa = reg_addr == `FLIC_ADDR_FLAG_A;
   wire sel_fb = reg_addr == `FLIC_ADDR_FLAG_B;
   wire sel_fc = reg_addr == `FLIC_ADDR_FLAG_C;
   wire sel_svc = reg_addr == `FLIC_ADDR_INSVC;

   wire wr_fa = reg_wr & sel_fa;
   wire wr_fb = reg_wr & sel_fb;
   wire wr_fc = reg_wr & sel_fc;

   // Hardware event detection
   wire ext0_edge = ext_irq_pin0 & ~ext0_prev_reg;
   wire ext1_edge = ext_irq_pin1 & ~ext1_prev_reg;
   wire [3:0] cap_edge = t2_in.capture & ~cap_prev_reg;
   // Compare only on a fresh count, so a cleared flag stays clear while the timer rests
   wire count_moved = t2_in.count != count_prev_reg;
   wire [2:0] cmp_hit;
   assign cmp_hit[0] = count_moved & (t2_in.count == t2_in.cmp0);
   assign cmp_hit[1] = count_moved & (t2_in.count == t2_in.cmp1);
   assign cmp_hit[2] = count_moved & (t2_in.count == t2_in.cmp2);
   wire byte_wrap = (count_prev_reg[7:0] == `FLIC_BYTE_MAX)
      & (t2_in.count[7:0] == `FLIC_BYTE_ZERO);
   wire word_wrap = (count_prev_reg == `FLIC_WORD_MAX)
      & (t2_in.count == `FLIC_WORD_ZERO);

   wire [7:0] set_a;
   assign set_a[`FLIC_FA_EXT0] = ext0_edge;
   assign set_a[`FLIC_FA_T0] = timer0_overflow;
   assign set_a[`FLIC_FA_EXT1] = ext1_edge;
   assign set_a[`FLIC_FA_T1] = timer1_overflow;
   assign set_a[`FLIC_FA_RX] = uart_rx_done;
   assign set_a[`FLIC_FA_TX] = uart_tx_done;
   assign set_a[`FLIC_FA_I2C] = i2c_status_load & i2c_status_valid;
   assign set_a[`FLIC_FA_ADC] = converter_result_ready;

   wire [6:0] set_b = {cmp_hit, cap_edge};
   wire [1:0] set_c;
   assign set_c[`FLIC_FC_BYTE_OV] = byte_wrap;
   assign set_c[`FLIC_FC_FULL_OV] = word_wrap;

   flic_flag_bank #(
      .W(8),
      .SET_OK(`FLIC_FA_SET_OK)
   ) u_flags_a (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .hw_set(set_a),
      .sw_wr(wr_fa),
      .sw_data(reg_wdata),
      .flags(flag_a)
   );

   flic_flag_bank #(
      .W(7),
      .SET_OK(`FLIC_FB_SET_OK)
   ) u_flags_b (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .hw_set(set_b),
      .sw_wr(wr_fb),
      .sw_data(reg_wdata[6:0]),
      .flags(flag_b)
   );

   flic_flag_bank #(
      .W(2),
      .SET_OK(`FLIC_FC_SET_OK)
   ) u_flags_c (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .hw_set(set_c),
      .sw_wr(wr_fc),
      .sw_data(reg_wdata[1:0]),
      .flags(flag_c)
   );

   // Source requests, in polling order
   wire uart_req = flag_a[`FLIC_FA_RX] | flag_a[`FLIC_FA_TX];
   wire ovf_req = flag_c[`FLIC_FC_BYTE_OV] | flag_c[`FLIC_FC_FULL_OV];
   wire [3:0] cap_req = flag_b[`FLIC_FB_CAP_LSB +: 4];
   wire [2:0] cmp_req = flag_b[`FLIC_FB_CMP_LSB +: 3];
   wire [`FLIC_NUM_SRC-1:0] src_req = {
      ovf_req,
      cmp_req,
      cap_req,
      flag_a[`FLIC_FA_ADC],
      flag_a[`FLIC_FA_I2C],
      uart_req,
      flag_a[`FLIC_FA_T1],
      flag_a[`FLIC_FA_EXT1],
      flag_a[`FLIC_FA_T0],
      flag_a[`FLIC_FA_EXT0]
   };

   // Enable and priority vectors share the source order
   wire global_irq_enable = ien_pri_reg[`FLIC_GLOBAL_BIT];
   wire [`FLIC_NUM_SRC-1:0] src_enable = {ien_sec_reg, ien_pri_reg[6:0]};
   wire [`FLIC_NUM_SRC-1:0] prio_lo = {prio_lo1_reg, prio_lo0_reg[6:0]};
   wire [`FLIC_NUM_SRC-1:0] prio_hi = {prio_hi1_reg, prio_hi0_reg[6:0]};
   wire [`FLIC_NUM_SRC-1:0] pend = src_req & src_enable
      & {`FLIC_NUM_SRC{global_irq_enable}};

   flic_grant_s win;

   flic_prio_pick u_pick (
      .req(pend),
      .prio_hi(prio_hi),
      .prio_lo(prio_lo),
      .grant(win)
   );

   // Nesting: a winner goes to the core only above the level in service
   wire svc_busy = |in_svc_reg;
   wire [1:0] svc_level = top_level(in_svc_reg);
   wire may_preempt = win.valid & (!svc_busy | (win.level > svc_level));

   always_comb begin
      grant_next = win;
      grant_next.valid = may_preempt;
   end

   // Return pops the top level first, so the stopped level becomes current again
   wire [3:0] svc_popped = core_in.ret
      ? (in_svc_reg & ~level_bit(svc_level)) : in_svc_reg;
   wire [3:0] svc_pushed = (core_in.ack & grant_reg.valid)
      ? level_bit(grant_reg.level) : 4'h0;
   assign in_svc_next = svc_popped | svc_pushed;

   // Read data
   always_comb begin
      rdata_next = `FLIC_RD_ZERO;
      if (reg_rd) begin
         if (sel_ien_pri) rdata_next = ien_pri_reg;
         if (sel_ien_sec) rdata_next = ien_sec_reg;
         if (sel_lo0) rdata_next = prio_lo0_reg;
         if (sel_hi0) rdata_next = prio_hi0_reg;
         if (sel_lo1) rdata_next = prio_lo1_reg;
         if (sel_hi1) rdata_next = prio_hi1_reg;
         if (sel_fa) rdata_next = flag_a;
         if (sel_fb) rdata_next = {1'b0, flag_b};
         if (sel_fc) rdata_next = {6'h00, flag_c};
         if (sel_svc) rdata_next = {4'h0, in_svc_reg};
      end
   end

   // Control registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ien_pri_reg <= `FLIC_REG_RST;
         ien_sec_reg <= `FLIC_REG_RST;
      end else begin
         if (reg_wr & sel_ien_pri) ien_pri_reg <= reg_wdata;
         if (reg_wr & sel_ien_sec) ien_sec_reg <= reg_wdata;
      end
   end

   // Unused top bit of the first group reads as zero
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prio_lo0_reg <= `FLIC_REG_RST;
         prio_hi0_reg <= `FLIC_REG_RST;
         prio_lo1_reg <= `FLIC_REG_RST;
         prio_hi1_reg <= `FLIC_REG_RST;
      end else begin
         if (reg_wr & sel_lo0) prio_lo0_reg <= {1'b0, reg_wdata[6:0]};
         if (reg_wr & sel_hi0) prio_hi0_reg <= {1'b0, reg_wdata[6:0]};
         if (reg_wr & sel_lo1) prio_lo1_reg <= reg_wdata;
         if (reg_wr & sel_hi1) prio_hi1_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ext0_prev_reg <= 1'b0;
         ext1_prev_reg <= 1'b0;
         cap_prev_reg <= 4'h0;
         count_prev_reg <= `FLIC_WORD_ZERO;
      end else begin
         ext0_prev_reg <= ext_irq_pin0;
         ext1_prev_reg <= ext_irq_pin1;
         cap_prev_reg <= t2_in.capture;
         count_prev_reg <= t2_in.count;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         in_svc_reg <= 4'h0;
         grant_reg <= '0;
         rdata_reg <= `FLIC_RD_ZERO;
      end else begin
         in_svc_reg <= in_svc_next;
         grant_reg <= grant_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign core_req = grant_reg;
   assign in_service = in_svc_reg;
endmodule : flic_top
`default_nettype wire

// ### test/flic_chk.sv
// Port checker for the interrupt controller
`default_nettype none
`include "flic_defines.svh"
module flic_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   // Sources
   input wire logic ext_irq_pin0,
   input wire flic_pkg::flic_t2_s t2_in,
   // Core link
   input wire flic_pkg::flic_core_s core_in,
   input wire flic_pkg::flic_grant_s core_req,
   input wire logic [3:0] in_service
);
   timeunit 1ns;
   timeprecision 1ns;
   import flic_pkg::*;
   logic [7:0] en_pri;
   logic [7:0] en_sec;
   logic [3:0] popped;
   logic open_gate;
   assign popped = in_service[3] ? {1'b0, in_service[2:0]} :
      in_service[2] ? {2'b00, in_service[1:0]} :
      in_service[1] ? {3'b000, in_service[0]} : 4'h0;
   assign open_gate = en_pri[7] && in_service == 4'h0 && !core_in.ack;
   // Enable mirrors: the checker sees the bus, not the registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         en_pri <= 8'h00;
         en_sec <= 8'h00;
      end else if (reg_wr) begin
         if (reg_addr == `FLIC_ADDR_IEN_PRI) en_pri <= reg_wdata;
         if (reg_addr == `FLIC_ADDR_IEN_SEC) en_sec <= reg_wdata;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   glob_off_a: assert property (!en_pri[7] [*2] |-> !core_req.valid)
      else $error("request while globally disabled");
   no_enable_a: assert property ((en_pri[6:0] == 7'h00 && en_sec == 8'h00) [*2]
      |-> !core_req.valid) else $error("request with every source disabled");
   wait_level_a: assert property (core_req.valid && $stable(in_service)
      |-> (in_service >> core_req.level) == 4'h0) else $error("request not above service");
   ack_push_a: assert property (core_in.ack && core_req.valid && !core_in.ret
      |=> in_service == ($past(in_service) | (4'h1 << $past(core_req.level))))
      else $error("ack did not push level");
   ret_pop_a: assert property (core_in.ret && !core_in.ack
      |=> in_service == $past(popped)) else $error("return did not pop top level");
   ack_drop_a: assert property (core_in.ack && !core_req.valid && !core_in.ret
      |=> $stable(in_service)) else $error("stray ack changed service");
   src_range_a: assert property (core_req.valid |-> core_req.source < 4'hf)
      else $error("source index out of range");
   ext0_req_a: assert property ($rose(ext_irq_pin0) && en_pri[0] && open_gate
      |-> ##[1:3] core_req.valid) else $error("pin 0 edge gave no request");
   cap_req_a: assert property ($rose(t2_in.capture[0]) && en_sec[0] && open_gate
      |-> ##[1:3] core_req.valid) else $error("capture 0 gave no request");
   ovf_req_a: assert property (t2_in.count == 16'h0000 && $past(t2_in.count) == 16'hffff
      && en_sec[7] && open_gate |-> ##[1:3] core_req.valid) else $error("wrap gave no request");
   cover property (in_service == 4'h9);
   cover property (core_in.ack && core_req.valid && in_service != 4'h0);
   cover property (core_in.ret && in_service != 4'h0);
endmodule : flic_chk
bind flic_top flic_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .ext_irq_pin0(ext_irq_pin0), .t2_in(t2_in),
   .core_in(core_in), .core_req(core_req), .in_service(in_service));
`default_nettype wire

// ### test/flic_core_model.sv
// Behavioural processor core that takes and returns vectored requests
`default_nettype none
module flic_core_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Bench controls
   input wire logic ack_en,
   input wire logic [3:0] ack_wait,
   input wire logic ret_cmd,
   // Controller side
   input wire flic_pkg::flic_grant_s core_req,
   output flic_pkg::flic_core_s core_in
);
   timeunit 1ns;
   timeprecision 1ns;
   import flic_pkg::*;
   logic [3:0] wait_reg;
   logic [1:0] hold_reg;
   // The grant lags the ack, so the core holds off to avoid taking it twice
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wait_reg <= 4'h0;
         hold_reg <= 2'h0;
         core_in <= '0;
      end else begin
         core_in.ret <= ret_cmd;
         core_in.ack <= 1'b0;
         if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
         end else if (ack_en && core_req.valid) begin
            wait_reg <= wait_reg + 4'h1;
            if (wait_reg >= ack_wait) begin
               core_in.ack <= 1'b1;
               hold_reg <= 2'h3;
               wait_reg <= 4'h0;
            end
         end else begin
            wait_reg <= 4'h0;
         end
      end
   end
endmodule : flic_core_model
`default_nettype wire

// ### test/flic_top_test.sv
// Self-checking bench for the interrupt controller
`default_nettype none
`include "flic_defines.svh"
module flic_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   import flic_pkg::*;
   logic clk_sys, rst_b, reg_wr, reg_rd, i2c_valid, ack_en, ret_cmd;
   logic [7:0] reg_addr, reg_wdata, ev;
   logic [3:0] ack_wait;
   logic [7:0] reg_rdata;
   logic [3:0] in_service;
   flic_t2_s t2_in;
   flic_core_s core_in;
   flic_grant_s core_req;
   int mismatches = 0;
   int comparisons = 0;
   wire logic [7:0] grant_view;
   wire logic [7:0] svc_view;
   // Level rides in bits 6:5 so that every grant check also judges the level handed to the core
   assign grant_view = {1'b0, core_req.level, core_req.valid, core_req.source};
   assign svc_view = {4'h0, in_service};
   flic_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin0(ev[0]),
      .ext_irq_pin1(ev[2]), .timer0_overflow(ev[1]), .timer1_overflow(ev[3]),
      .uart_rx_done(ev[4]), .uart_tx_done(ev[5]), .i2c_status_load(ev[6]),
      .i2c_status_valid(i2c_valid), .converter_result_ready(ev[7]), .t2_in(t2_in),
      .core_in(core_in), .core_req(core_req), .in_service(in_service));
   flic_core_model core (.clk_sys(clk_sys), .rst_b(rst_b), .ack_en(ack_en),
      .ack_wait(ack_wait), .ret_cmd(ret_cmd), .core_req(core_req), .core_in(core_in));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask : rd_chk
   task automatic pulse(input logic [7:0] m);
      @(posedge clk_sys);
      ev <= m;
      @(posedge clk_sys);
      ev <= 8'h00;
   endtask : pulse
   task automatic cnt(input logic [15:0] v);
      @(posedge clk_sys);
      t2_in.count <= v;
   endtask : cnt
   task automatic grant_chk(input logic [7:0] exp);
      repeat (3) @(posedge clk_sys);
      #1 check(grant_view, exp);
   endtask : grant_chk
   task automatic wait_svc(input logic [3:0] exp);
      int n = 0;
      // Look only after the edge has settled, never in the step that updates it
      #1;
      while (in_service !== exp && n < 30) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check(svc_view, {4'h0, exp});
   endtask : wait_svc
   task automatic ret_pulse;
      @(posedge clk_sys);
      ret_cmd <= 1'b1;
      @(posedge clk_sys);
      ret_cmd <= 1'b0;
   endtask : ret_pulse
   task automatic t_regs;
      logic [7:0] adr [6] = '{`FLIC_ADDR_IEN_PRI, `FLIC_ADDR_IEN_SEC, `FLIC_ADDR_PRIO_LO0,
         `FLIC_ADDR_PRIO_HI0, `FLIC_ADDR_PRIO_LO1, `FLIC_ADDR_PRIO_HI1};
      foreach (adr[i]) begin
         rd_chk(adr[i], 8'h00);
         wr(adr[i], 8'h5a);
         rd_chk(adr[i], 8'h5a);
         wr(adr[i], 8'h00);
      end
      wr(8'h10, 8'hff);
      rd_chk(8'h10, 8'h00);
      wr(`FLIC_ADDR_INSVC, 8'h0f);
      rd_chk(`FLIC_ADDR_INSVC, 8'h00);
   endtask : t_regs
   task automatic t_flags;
      pulse(8'h40);
      rd_chk(`FLIC_ADDR_FLAG_A, 8'h00);
      @(posedge clk_sys);
      i2c_valid <= 1'b1;
      pulse(8'hff);
      repeat (20) @(posedge clk_sys);
      rd_chk(`FLIC_ADDR_FLAG_A, 8'hff);
      wr(`FLIC_ADDR_FLAG_A, 8'h7f);
      rd_chk(`FLIC_ADDR_FLAG_A, 8'h7f);
      wr(`FLIC_ADDR_FLAG_A, 8'h80);
      rd_chk(`FLIC_ADDR_FLAG_A, 8'h00);
      wr(`FLIC_ADDR_FLAG_A, 8'h7f);
      rd_chk(`FLIC_ADDR_FLAG_A, 8'h7f);
      wr(`FLIC_ADDR_FLAG_A, 8'h00);
   endtask : t_flags
   task automatic t_t2;
      wr(`FLIC_ADDR_IEN_PRI, 8'h80);
      wr(`FLIC_ADDR_IEN_SEC, 8'h81);
      cnt(16'h0005);
      cnt(16'h0006);
      cnt(16'h0007);
      t2_in.capture <= 4'hf;
      repeat (20) @(posedge clk_sys);
      rd_chk(`FLIC_ADDR_FLAG_B, 8'h7f);
      wr(`FLIC_ADDR_FLAG_B, 8'h00);
      cnt(16'h12ff);
      cnt(16'h1300);
      rd_chk(`FLIC_ADDR_FLAG_C, 8'h01);
      wr(`FLIC_ADDR_FLAG_C, 8'h00);
      cnt(16'hffff);
      cnt(16'h0000);
      rd_chk(`FLIC_ADDR_FLAG_C, 8'h03);
      @(posedge clk_sys);
      t2_in.capture <= 4'h0;
   endtask : t_t2
   task automatic t_poll;
      wr(`FLIC_ADDR_FLAG_A, 8'h7f);
      pulse(8'h80);
      wr(`FLIC_ADDR_FLAG_B, 8'h7f);
      wr(`FLIC_ADDR_FLAG_C, 8'h01);
      wr(`FLIC_ADDR_IEN_SEC, 8'h00);
      for (int b = 0; b < 7; b++) begin
         wr(`FLIC_ADDR_IEN_PRI, 8'h80 | (8'h01 << b));
         grant_chk({4'h1, 4'(b)});
      end
      wr(`FLIC_ADDR_IEN_PRI, 8'h80);
      for (int b = 0; b < 8; b++) begin
         wr(`FLIC_ADDR_IEN_SEC, 8'h01 << b);
         grant_chk({4'h1, 4'(b + 7)});
      end
      wr(`FLIC_ADDR_IEN_SEC, 8'hff);
      grant_chk(8'h17);
      wr(`FLIC_ADDR_IEN_PRI, 8'hff);
      grant_chk(8'h10);
      wr(`FLIC_ADDR_PRIO_HI1, 8'h80);
      grant_chk(8'h5e);
      wr(`FLIC_ADDR_IEN_SEC, 8'h7f);
      grant_chk(8'h10);
      wr(`FLIC_ADDR_IEN_PRI, 8'h7f);
      grant_chk(8'h00);
      wr(`FLIC_ADDR_PRIO_HI1, 8'h00);
      wr(`FLIC_ADDR_IEN_SEC, 8'h00);
      wr(`FLIC_ADDR_FLAG_A, 8'h00);
      wr(`FLIC_ADDR_FLAG_B, 8'h00);
      wr(`FLIC_ADDR_FLAG_C, 8'h00);
   endtask : t_poll
   task automatic t_nest;
      ack_en <= 1'b1;
      wr(`FLIC_ADDR_IEN_PRI, 8'h85);
      for (int l = 0; l < 4; l++) begin
         ack_wait <= 4'(2 * l);
         wr(`FLIC_ADDR_PRIO_LO0, {7'h00, l[0]});
         wr(`FLIC_ADDR_PRIO_HI0, {7'h00, l[1]});
         pulse(8'h01);
         wait_svc(4'h1 << l);
         wr(`FLIC_ADDR_FLAG_A, 8'h00);
         ret_pulse;
         wait_svc(4'h0);
      end
      wr(`FLIC_ADDR_PRIO_LO0, 8'h04);
      wr(`FLIC_ADDR_PRIO_HI0, 8'h04);
      pulse(8'h01);
      wait_svc(4'h1);
      grant_chk(8'h00);
      pulse(8'h04);
      wait_svc(4'h9);
      wr(`FLIC_ADDR_FLAG_A, 8'h01);
      ret_pulse;
      wait_svc(4'h1);
      @(posedge clk_sys);
      ack_en <= 1'b0;
      ret_pulse;
      wait_svc(4'h0);
      grant_chk(8'h10);
      wr(`FLIC_ADDR_FLAG_A, 8'h00);
      grant_chk(8'h00);
   endtask : t_nest
   task automatic complete_run;
      if (mismatches == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      {reg_wr, reg_rd, i2c_valid, ack_en, ret_cmd} = 5'h00;
      {reg_addr, reg_wdata, ev} = 24'h0000_00;
      ack_wait = 4'h0;
      t2_in = {16'h0000, 16'h0005, 16'h0006, 16'h0007, 4'h0};
      rst_b = 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_regs;
      t_flags;
      t_t2;
      t_poll;
      t_nest;
      complete_run;
   end
   // Whole run is near 400 cycles; fifty times that means a hang
   initial begin
      #2_000_000;
      mismatches++;
      complete_run;
   end
endmodule : flic_top_test
`default_nettype wire
